/* core/clock_cycle_counter.sv */
// free-running master-clock cycle counter with enable
`timescale 1ns/1ps
module clock_cycle_counter #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // control
    input wire logic i_enable,
    // count
    output logic [WIDTH-1:0] o_count
);
    initial begin
        if (WIDTH < 1) begin
            $error("counter width must be positive");
        end
    end

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    assign count_d = i_enable ? count_q + WIDTH'(1) : count_q; // [R02]
    assign o_count = count_q;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule : clock_cycle_counter

/* core/error_check_enable_pkg.sv */
// types for the error check enable bank
package error_check_enable_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [6:0] flag_vec_t;
    typedef enum logic [1:0] {
        FRAME_IDLE = 2'h0,
        FRAME_BUSY = 2'h1,
        FRAME_DONE = 2'h3
    } frame_state_t;
endpackage : error_check_enable_pkg

/* core/error_check_enable_register.sv */
// error check enable register with its gated flag sources
`timescale 1ns/1ps
`include "error_check_enable_regs.svh"
module error_check_enable_register #(
    parameter int COUNT_WIDTH = 32,
    parameter int ADDR_WIDTH = 6
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // register access from the serial interface
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_WIDTH-1:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output error_check_enable_pkg::reg_word_t o_reg_rdata,
    output logic o_reg_hit,
    // serial frame monitor
    input wire logic i_cs_active,
    input wire logic i_sclk_rise,
    input wire logic i_frame_is_write,
    input wire logic i_chip_select_required,
    // device conditions
    input wire logic i_positive_analog_input_fault,
    input wire logic i_negative_analog_input_fault,
    input wire logic i_reference_input_fault,
    input wire logic i_reference_input_missing,
    input wire logic i_conversion_fault,
    input wire logic i_fuse_copy_busy,
    input wire logic i_calibration_busy,
    // enable values and gated flag requests
    output error_check_enable_pkg::reg_word_t o_enable,
    output error_check_enable_pkg::flag_vec_t o_flag_set,
    output logic o_write_abort,
    output logic [COUNT_WIDTH-1:0] o_clock_count
);
    import error_check_enable_pkg::*;

    initial begin
        if (ADDR_WIDTH < 3) begin
            $error("address width too small for the register address");
        end
        if (COUNT_WIDTH < 1) begin
            $error("counter width must be positive");
        end
        if ($bits(flag_vec_t) != `FLG_COUNT) begin
            $error("flag vector does not match the flag positions");
        end
    end

    // ===================================
    // register decode
    reg_word_t enable_q;
    reg_word_t enable_d;
    reg_word_t write_word;
    wire addr_hit;
    wire any_write;
    wire any_read;
    wire write_locked;
    wire reg_write;
    wire reg_read;

    assign addr_hit = (i_reg_addr == ADDR_WIDTH'(`ERR_EN_ADDR)); // [R01]
    assign any_write = i_reg_wr;
    assign any_read = i_reg_rd;
    assign write_locked = i_fuse_copy_busy || i_calibration_busy; // [R09] [R10]
    assign reg_write = any_write && addr_hit && !write_locked; // [R09] [R10]
    assign reg_read = any_read && addr_hit;
    assign write_word = i_reg_wdata & `ERR_EN_WMASK; // [R16]
    assign enable_d = reg_write ? write_word : enable_q;
    assign o_reg_hit = addr_hit && (any_write || any_read);

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            enable_q <= `ERR_EN_RESET; // [R01] [R08]
        end else begin
            enable_q <= enable_d;
        end
    end

    // ===================================
    // read data
    reg_word_t rdata_q;
    reg_word_t read_word;

    assign read_word = enable_q & `ERR_EN_WMASK; // [R16]

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            rdata_q <= '0;
        end else if (reg_read) begin
            rdata_q <= read_word;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_enable = enable_q;

    // ===================================
    // enable fields
    wire master_clock_counter_enable;
    wire positive_input_range_check_enable;
    wire negative_input_range_check_enable;
    wire reference_range_check_enable;
    wire reference_presence_check_enable;
    wire conversion_check_enable;
    wire ignored_write_check_enable;
    wire serial_clock_count_check_enable;

    assign master_clock_counter_enable = enable_q[`BIT_MCLK_CNT]; // [R02]
    assign positive_input_range_check_enable = enable_q[`BIT_POS_IN]; // [R03]
    assign negative_input_range_check_enable = enable_q[`BIT_NEG_IN]; // [R04]
    assign reference_range_check_enable = enable_q[`BIT_REF_RANGE]; // [R05]
    assign reference_presence_check_enable = enable_q[`BIT_REF_DET]; // [R06]
    assign conversion_check_enable = enable_q[`BIT_CONV]; // [R07]
    assign ignored_write_check_enable = enable_q[`BIT_IGNORE]; // [R08]
    assign serial_clock_count_check_enable = enable_q[`BIT_SCLK_CNT]; // [R11]

    // ===================================
    // master-clock counter
    clock_cycle_counter #(
        .WIDTH(COUNT_WIDTH)
    ) u_counter (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_enable(master_clock_counter_enable), // [R02]
        .o_count(o_clock_count)
    );

    // ===================================
    // serial frame tracking
    frame_state_t frame_q;
    frame_state_t frame_d;
    logic [2:0] sclk_mod_q;
    logic [2:0] sclk_mod_d;
    logic write_q;
    logic write_d;
    wire frame_idle;
    wire frame_busy;
    wire frame_done;
    wire frame_start;
    wire frame_end;
    wire sclk_step;
    wire [2:0] sclk_first;
    wire [2:0] sclk_next;

    assign frame_idle = (frame_q == FRAME_IDLE);
    assign frame_busy = (frame_q == FRAME_BUSY);
    assign frame_done = (frame_q == FRAME_DONE);
    assign frame_start = (frame_idle || frame_done) && i_cs_active; // [R12]
    assign frame_end = frame_busy && !i_cs_active;
    assign sclk_step = frame_busy && i_cs_active && i_sclk_rise; // [R12]
    assign sclk_first = i_sclk_rise ? 3'h1 : `SCLK_PER_BYTE; // [R12]
    assign sclk_next = sclk_mod_q + 3'h1;

    // a frame may open in the cycle right after the last one closed
    always_comb begin
        frame_d = frame_q;
        sclk_mod_d = sclk_mod_q;
        write_d = write_q;
        case (frame_q)
            FRAME_IDLE: begin
                if (frame_start) begin
                    frame_d = FRAME_BUSY;
                    sclk_mod_d = sclk_first;
                    write_d = i_frame_is_write;
                end
            end
            FRAME_BUSY: begin
                if (frame_end) begin
                    frame_d = FRAME_DONE;
                end else if (sclk_step) begin
                    sclk_mod_d = sclk_next; // [R12]
                end
                if (i_cs_active && i_frame_is_write) begin
                    write_d = 1'b1;
                end
            end
            FRAME_DONE: begin
                if (frame_start) begin
                    frame_d = FRAME_BUSY;
                    sclk_mod_d = sclk_first;
                    write_d = i_frame_is_write;
                end else begin
                    frame_d = FRAME_IDLE;
                end
            end
            default: begin
                frame_d = FRAME_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            frame_q <= FRAME_IDLE;
            sclk_mod_q <= 3'h0;
            write_q <= 1'b0;
        end else begin
            frame_q <= frame_d;
            sclk_mod_q <= sclk_mod_d;
            write_q <= write_d;
        end
    end

    // ===================================
    // serial clock count check
    wire count_check_on;
    wire [2:0] count_residue;
    wire count_bad;
    wire count_short;

    assign count_check_on = serial_clock_count_check_enable && i_chip_select_required; // [R11]
    assign count_residue = sclk_mod_q & `SCLK_MOD_MASK;
    assign count_bad = frame_end && (count_residue != `SCLK_PER_BYTE); // [R14]
    assign count_short = count_bad && write_q; // [R15]
    assign o_write_abort = count_check_on && count_short; // [R15]

    // ===================================
    // gated flag requests
    wire ignored_write;
    wire [`FLG_COUNT-1:0] check_enable;
    wire [`FLG_COUNT-1:0] check_event;
    flag_vec_t flag_d;

    assign ignored_write = any_write && write_locked; // [R09] [R10]

    assign check_enable[`FLG_POS_IN] = positive_input_range_check_enable; // [R03]
    assign check_enable[`FLG_NEG_IN] = negative_input_range_check_enable; // [R04]
    assign check_enable[`FLG_REF_RANGE] = reference_range_check_enable; // [R05]
    assign check_enable[`FLG_REF_DET] = reference_presence_check_enable; // [R06]
    assign check_enable[`FLG_CONV] = conversion_check_enable; // [R07]
    assign check_enable[`FLG_IGNORE] = ignored_write_check_enable; // [R08]
    assign check_enable[`FLG_SCLK_CNT] = count_check_on; // [R11]

    assign check_event[`FLG_POS_IN] = i_positive_analog_input_fault; // [R03]
    assign check_event[`FLG_NEG_IN] = i_negative_analog_input_fault; // [R04]
    assign check_event[`FLG_REF_RANGE] = i_reference_input_fault; // [R05]
    assign check_event[`FLG_REF_DET] = i_reference_input_missing; // [R06]
    assign check_event[`FLG_CONV] = i_conversion_fault; // [R07]
    assign check_event[`FLG_IGNORE] = ignored_write; // [R09] [R10]
    assign check_event[`FLG_SCLK_CNT] = count_bad; // [R14]

    // a cleared enable bit blocks its flag whatever the condition does
    assign flag_d = check_enable & check_event; // [R17]

    flag_vec_t flag_q;
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign o_flag_set = flag_q;
endmodule : error_check_enable_register

/* core/error_check_enable_regs.svh */
// register constants for the error check enable bank
//
// Operation
// [R01] 16-bit enable register at 0x07, reset 0x0040
// [R02] bit 12 runs master-clock cycle counter
// [R03] bit 11 gates positive input range flag
// [R04] bit 10 gates negative input range flag
// [R05] bit 9 gates reference range flag
// [R06] presence enable gates reference missing flag
// [R07] conversion enable gates conversion error flag
// [R08] bit 6 ignored-write check, resets to one
// [R09] flag writes during fuse copy
// [R10] flag writes during offset/gain calibration
// [R11] clock count check needs chip-select-required too
// [R12] count serial clocks per framed transaction
// [R13] host frames each transaction with chip select
// [R14] count not multiple of eight sets flag
// [R15] short write aborted, register unchanged
// [R16] bits 15 to 13 read zero
// [R17] disabled enable bit never raises flag
`ifndef ERROR_CHECK_ENABLE_REGS_SVH
`define ERROR_CHECK_ENABLE_REGS_SVH

// ===================================
// addresses and reset
`define ERR_EN_ADDR 6'h07
`define ERR_EN_RESET 16'h0040
`define ERR_EN_WMASK 16'h1fff

// ===================================
// field positions
`define BIT_MCLK_CNT 12
`define BIT_POS_IN 11
`define BIT_NEG_IN 10
`define BIT_REF_RANGE 9
`define BIT_REF_DET 8
`define BIT_CONV 7
`define BIT_IGNORE 6
`define BIT_SCLK_CNT 5

// ===================================
// flag vector positions
`define FLG_POS_IN 0
`define FLG_NEG_IN 1
`define FLG_REF_RANGE 2
`define FLG_REF_DET 3
`define FLG_CONV 4
`define FLG_IGNORE 5
`define FLG_SCLK_CNT 6
`define FLG_COUNT 7

// ===================================
// serial word size
`define SCLK_PER_BYTE 3'h0
`define SCLK_MOD_MASK 3'h7

`endif

/* testbench/error_check_enable_monitor.sv */
// checker for the error check enable bank
`timescale 1ns/1ps
module error_check_enable_monitor #(
    parameter int COUNT_WIDTH = 32
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_fuse_copy_busy,
    input wire logic i_calibration_busy,
    input wire logic i_cs_active,
    input wire logic i_sclk_rise,
    input wire logic i_chip_select_required,
    input wire logic [15:0] o_enable,
    input wire logic [6:0] o_flag_set,
    input wire logic [COUNT_WIDTH-1:0] o_clock_count
);
    // ====
    // serial clocks seen in the current frame, mod 8
    logic [2:0] sclk_q;
    wire busy = i_fuse_copy_busy || i_calibration_busy;
    wire count_on = o_enable[5] && i_chip_select_required && sclk_q != 3'h0;
    always_ff @(posedge i_mclk) begin
        sclk_q <= i_cs_active ? sclk_q + {2'h0, i_sclk_rise} : 3'h0;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    reserved_zero_a: assert property (o_enable[15:13] == 3'h0) else $error("reserved set");
    ignored_wr_a: assert property (i_reg_wr && busy |=> $stable(o_enable)) else $error("wr taken");
    ignore_flag_a: assert property (i_reg_wr && busy && o_enable[6] |=> o_flag_set[5])
        else $error("no ignore flag");
    ignore_gate_a: assert property (!o_enable[6] |=> !o_flag_set[5]) else $error("ignore ungated");
    count_run_a: assert property (o_enable[12] |=> o_clock_count == $past(o_clock_count) + 1'b1)
        else $error("count stuck");
    count_hold_a: assert property (!o_enable[12] |=> $stable(o_clock_count)) else $error("count moved");
    sclk_flag_a: assert property ($fell(i_cs_active) && count_on |=> o_flag_set[6]) else $error("no sclk flag");
    sclk_gate_a: assert property (!o_enable[5] || !i_chip_select_required |=> !o_flag_set[6])
        else $error("sclk ungated");
    cover property (i_reg_wr && busy);
    cover property ($fell(i_cs_active) && count_on);
    cover property (o_enable[12]);
endmodule : error_check_enable_monitor
bind error_check_enable_register error_check_enable_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) i_mon (.i_mclk,
    .i_reset_n, .i_reg_wr, .i_fuse_copy_busy, .i_calibration_busy, .i_cs_active, .i_sclk_rise,
    .i_chip_select_required, .o_enable, .o_flag_set, .o_clock_count);

/* testbench/serial_host_model.sv */
// host model framing serial transactions
`timescale 1ns/1ps
module serial_host_model (
    input wire logic i_mclk,
    output logic o_cs_active = 1'b0,
    output logic o_sclk_rise = 1'b0,
    output logic o_frame_is_write = 1'b0
);
    task automatic frame(input int n, input logic w);
        @(posedge i_mclk) #1 o_cs_active = 1'b1;
        o_frame_is_write = w;
        repeat (n) begin
            @(posedge i_mclk) #1 o_sclk_rise = 1'b1;
            @(posedge i_mclk) #1 o_sclk_rise = 1'b0;
        end
        @(posedge i_mclk) #1 o_cs_active = 1'b0;
        o_frame_is_write = ~w;
    endtask : frame
endmodule : serial_host_model

/* testbench/tb_error_check_enable_register.sv */
// self-checking bench for the error check enable bank
`timescale 1ns/1ps
module tb_error_check_enable_register;
    import error_check_enable_pkg::*;
    logic i_mclk = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_chip_select_required = 1'b0;
    logic i_fuse_copy_busy = 1'b0, i_calibration_busy = 1'b0;
    logic [5:0] i_reg_addr = 6'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [4:0] fault = 5'h00;
    logic i_cs_active, i_sclk_rise, i_frame_is_write, o_reg_hit, o_write_abort;
    reg_word_t o_reg_rdata, o_enable;
    flag_vec_t o_flag_set;
    logic [31:0] o_clock_count;
    int n_mismatch = 0, cmp_count = 0;
    always #25 i_mclk = ~i_mclk;
    serial_host_model i_host (.i_mclk, .o_cs_active(i_cs_active), .o_sclk_rise(i_sclk_rise),
        .o_frame_is_write(i_frame_is_write));
    error_check_enable_register i_dut (.i_mclk, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_hit, .i_cs_active, .i_sclk_rise, .i_frame_is_write, .i_chip_select_required,
        .i_positive_analog_input_fault(fault[0]), .i_negative_analog_input_fault(fault[1]),
        .i_reference_input_fault(fault[2]), .i_reference_input_missing(fault[3]), .i_conversion_fault(fault[4]),
        .i_fuse_copy_busy, .i_calibration_busy, .o_enable, .o_flag_set, .o_write_abort, .o_clock_count);
    // ====
    // access and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        #1 chk(o_reg_hit, a == 6'h07);
        @(posedge i_mclk) #1 i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] exp);
        i_reg_rd = 1'b1;
        i_reg_addr = 6'h07;
        @(posedge i_mclk) #1 i_reg_rd = 1'b0;
        chk(o_reg_rdata, exp);
    endtask : rd
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200us n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge i_mclk);
        #1 i_reset_n = 1'b1;
        rd(16'h0040);
        wr(6'h07, 16'h1000);
        repeat (9) @(posedge i_mclk);
        #1 wr(6'h07, 16'h0000);
        repeat (3) @(posedge i_mclk);
        #1 chk(o_clock_count, 32'h0000000a);
        wr(6'h07, 16'hffff);
        rd(16'h1fff);
        chk(o_enable, 16'h1fff);
        for (int i = 0; i < 2; i++) begin
            {i_calibration_busy, i_fuse_copy_busy} = 2'(i + 1);
            wr(6'h07, 16'h0000);
            chk(o_flag_set[5], 1'b1);
            {i_calibration_busy, i_fuse_copy_busy} = 2'h0;
            rd(16'h1fff);
        end
        wr(6'h08, 16'h0000);
        rd(16'h1fff);
        fault = 5'h1f;
        @(posedge i_mclk) #1 chk(o_flag_set[4:0], 5'h1f);
        wr(6'h07, 16'h0000);
        @(posedge i_mclk) #1 chk(o_flag_set, 7'h00);
        fault = 5'h00;
        wr(6'h07, 16'h0020);
        for (int i = 0; i < 4; i++) begin
            i_chip_select_required = i != 2;
            i_host.frame(7 + i, i != 3);
            #1 chk(o_write_abort, i == 0);
            @(posedge i_mclk) #1 chk(o_flag_set[6], i == 0 || i == 3);
        end
        // ignored write with its check disabled raises nothing
        i_fuse_copy_busy = 1'b1;
        wr(6'h07, 16'h0000);
        chk(o_flag_set[5], 1'b0);
        i_fuse_copy_busy = 1'b0;
        rd(16'h0020);
        // mid-run reset clears the counter and restores the enables
        i_reset_n = 1'b0;
        repeat (2) @(posedge i_mclk);
        #1 i_reset_n = 1'b1;
        chk(o_clock_count, 32'h00000000);
        rd(16'h0040);
        print_verdict();
    end
endmodule : tb_error_check_enable_register
